// ==== logic/rail_level_decode.sv ====
`timescale 1ns/1ps
`include "supply_regulator_params.svh"
module rail_level_decode
	import supply_regulator_pkg::*;
(
	// selection
	input wire logic supply_5v,
	input wire logic [2:0] code,
	// levels
	output level_t amp_level,
	output level_t ana_level
);
	// manual table for both supply configurations
	always_comb begin
		if (supply_5v) begin
			amp_level = level_t'(`LEVEL_4V3 + {3'h0, code});
			ana_level = `LEVEL_3V4;
		end else begin
			amp_level = level_t'(`LEVEL_2V7 + {3'h0, code});
			ana_level = amp_level;
		end
	end
endmodule // rail_level_decode

// ==== logic/supply_regulator_params.svh ====
`ifndef SUPPLY_REGULATOR_PARAMS_SVH
`define SUPPLY_REGULATOR_PARAMS_SVH
// register offsets
`define SUPPLY_MODE_POWER_CONTROL_OFS 8'h00
`define SUPPLY_LEVEL_CONTROL_OFS 8'h0b
// field positions
`define SUPPLY_MODE_BIT 0
`define AUTO_MODE_BIT 7
// reset values: 5-V configuration, automatic mode
`define SUPPLY_MODE_POWER_CONTROL_RST 8'h01
`define SUPPLY_LEVEL_CONTROL_RST 8'h80
// level codes in 100 mV units
`define LEVEL_5V0 6'h32
`define LEVEL_4V3 6'h2b
`define LEVEL_3V4 6'h22
`define LEVEL_2V7 6'h1b
`define DELTA_400MV 6'h04
// settling time of the automatic routine
`define SETTLE_TIME_NS 1000
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + 24) / 25)
`endif

// ==== logic/supply_regulator_pkg.sv ====
package supply_regulator_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MEASURE = 3'b010,
		ST_SETTLE = 3'b100
	} auto_state_t;
	typedef logic [5:0] level_t;
endpackage

// ==== logic/supply_regulator_setting_control.sv ====
`timescale 1ns/1ps
`include "supply_regulator_params.svh"
module supply_regulator_setting_control
	import supply_regulator_pkg::*;
(
	// clock and reset
	input wire logic host_clock_output,
	input wire logic rst_b,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// pins and measurement
	input wire logic chip_activate,
	input wire logic [5:0] vin_level,
	// regulator and oscillator controls
	output logic regulators_on,
	output logic osc_run,
	output logic host_clock_output_en,
	output logic [5:0] amplifier_rail,
	output logic [5:0] analog_rail,
	output logic [5:0] digital_rail,
	output logic auto_busy
);
	// settle length in clocks, rounded up so the rails always get the full time
	localparam int SETTLE_N = `SETTLE_CYCLES;

	// register images
	logic [7:0] mode_ctl_ff;
	logic [7:0] level_ctl_ff;
	// pin synchronisers and activation edge
	logic act_s1_ff, act_s2_ff, act_prev_ff;
	logic act_rise;
	// automatic routine
	logic auto_start;
	logic level_wr;
	auto_state_t state_ff;
	logic [15:0] settle_cnt_ff;
	level_t vin_s1_ff, vin_s2_ff;
	level_t auto_amp_ff, auto_ana_ff;
	level_t nxt_auto_amp, nxt_auto_ana, vin_minus;
	// manual table results
	level_t man_amp, man_ana;
	// mode and read path
	logic auto_mode;
	logic [7:0] nxt_rdata;

	// manual/automatic choice comes straight from the stored bit
	assign auto_mode = level_ctl_ff[`AUTO_MODE_BIT];

	// pin synchronisers; input level may change between edges
	always_ff @(posedge host_clock_output) begin
		if (!rst_b) begin
			act_s1_ff <= 1'b0;
			act_s2_ff <= 1'b0;
			act_prev_ff <= 1'b0;
			vin_s1_ff <= '0;
			vin_s2_ff <= '0;
		end else begin
			act_s1_ff <= chip_activate;
			act_s2_ff <= act_s1_ff;
			act_prev_ff <= act_s2_ff;
			vin_s1_ff <= vin_level;
			vin_s2_ff <= vin_s1_ff;
		end
	end

	// register writes
	always_ff @(posedge host_clock_output) begin
		if (!rst_b) begin
			level_ctl_ff <= `SUPPLY_LEVEL_CONTROL_RST;
			mode_ctl_ff <= `SUPPLY_MODE_POWER_CONTROL_RST;
		end else if (reg_wr) begin
			if (reg_addr == `SUPPLY_MODE_POWER_CONTROL_OFS) begin
				mode_ctl_ff <= reg_wdata;
			end else if (reg_addr == `SUPPLY_LEVEL_CONTROL_OFS) begin
				level_ctl_ff <= reg_wdata;
			end
		end
	end

	// activation edge seen in the same clock that the synchronised level rises
	assign act_rise = act_s2_ff && !act_prev_ff;
	// write strobe aimed at the level register
	assign level_wr = reg_wr && (reg_addr == `SUPPLY_LEVEL_CONTROL_OFS);

	// auto bit rising edge, or activation edge while in automatic mode
	// judged against the stored bit, so writing 1 over 1 does nothing
	assign auto_start = (act_rise && auto_mode)
		|| (level_wr && reg_wdata[`AUTO_MODE_BIT] && !auto_mode);

	always_comb begin
		vin_minus = (vin_s2_ff > `DELTA_400MV) ? level_t'(vin_s2_ff - `DELTA_400MV) : '0;
		nxt_auto_amp = (vin_minus > `LEVEL_5V0) ? `LEVEL_5V0 : vin_minus;
		nxt_auto_ana = (vin_minus > `LEVEL_3V4) ? `LEVEL_3V4 : vin_minus;
	end

	// automatic routine: sample input then hold result while rails settle
	always_ff @(posedge host_clock_output) begin
		if (!rst_b) begin
			state_ff <= ST_IDLE;
			settle_cnt_ff <= '0;
			auto_amp_ff <= `LEVEL_5V0;
			auto_ana_ff <= `LEVEL_3V4;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (auto_start) begin
						state_ff <= ST_MEASURE;
					end
				end
				ST_MEASURE: begin
					auto_amp_ff <= nxt_auto_amp;
					auto_ana_ff <= nxt_auto_ana;
					settle_cnt_ff <= 16'(SETTLE_N - 1);
					state_ff <= ST_SETTLE;
				end
				ST_SETTLE: begin
					// restart while settling
					// a new request is not lost while settling, but one arriving in ST_MEASURE is dropped
					if (auto_start) begin
						state_ff <= ST_MEASURE;
					end else if (settle_cnt_ff == '0) begin
						state_ff <= ST_IDLE;
					end else begin
						settle_cnt_ff <= settle_cnt_ff - 16'h0001;
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	rail_level_decode u_decode (
		.supply_5v(mode_ctl_ff[`SUPPLY_MODE_BIT]),
		.code(level_ctl_ff[2:0]),
		.amp_level(man_amp),
		.ana_level(man_ana)
	);

	// rail outputs registered to avoid glitching the analog trims
	always_ff @(posedge host_clock_output) begin
		if (!rst_b) begin
			amplifier_rail <= `LEVEL_5V0;
			analog_rail <= `LEVEL_3V4;
			digital_rail <= `LEVEL_3V4;
		end else if (auto_mode) begin
			amplifier_rail <= auto_amp_ff;
			analog_rail <= auto_ana_ff;
			digital_rail <= auto_ana_ff;
		end else begin
			amplifier_rail <= man_amp;
			analog_rail <= man_ana;
			digital_rail <= man_ana;
		end
	end

	always_ff @(posedge host_clock_output) begin
		if (!rst_b) begin
			regulators_on <= 1'b0;
			osc_run <= 1'b0;
			host_clock_output_en <= 1'b0;
		end else begin
			regulators_on <= act_s2_ff;
			osc_run <= act_s2_ff;
			host_clock_output_en <= act_s2_ff;
		end
	end

	// busy straight from the state so it rises with the routine, no extra lag
	assign auto_busy = (state_ff != ST_IDLE);

	// read data; unmapped offsets read zero
	always_comb begin
		if (reg_addr == `SUPPLY_MODE_POWER_CONTROL_OFS) begin
			nxt_rdata = mode_ctl_ff;
		end else if (reg_addr == `SUPPLY_LEVEL_CONTROL_OFS) begin
			nxt_rdata = level_ctl_ff;
		end else begin
			nxt_rdata = 8'h00;
		end
	end

	// read data captured on the strobe and held until the next read
	always_ff @(posedge host_clock_output) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= nxt_rdata;
		end
	end
endmodule // supply_regulator_setting_control

// ==== test/supply_reg_assertions.sv ====
`timescale 1ns/1ps
module supply_reg_chk (
	// watched ports
	input wire logic host_clock_output,
	input wire logic rst_b,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic auto_busy,
	input wire logic [5:0] amplifier_rail,
	input wire logic [5:0] analog_rail,
	input wire logic [5:0] digital_rail
);
	logic auto_ff;
	logic sup_ff;
	default clocking @(posedge host_clock_output); endclocking
	default disable iff (!rst_b);
	// mode bit shadows, so no body state is needed
	always_ff @(posedge host_clock_output) begin
		if (!rst_b) begin
			auto_ff <= 1'b1;
			sup_ff <= 1'b1;
		end else if (reg_wr && reg_addr == 8'h0b) auto_ff <= reg_wdata[7];
		else if (reg_wr && reg_addr == 8'h00) sup_ff <= reg_wdata[0];
	end
	auto_start_a: assert property (reg_wr && reg_addr == 8'h0b && reg_wdata[7] && !auto_ff |=> auto_busy)
		else $error("no start");
	no_rerun_a: assert property (reg_wr && reg_addr == 8'h0b && auto_ff && !auto_busy |=> !auto_busy)
		else $error("rerun");
	run_hold_a: assert property ($rose(auto_busy) |-> auto_busy[*8])
		else $error("short run");
	run_end_a: assert property ($rose(auto_busy) |-> ##[8:60] !auto_busy)
		else $error("run hangs");
	amp_cap_a: assert property (amplifier_rail <= 6'h32)
		else $error("amp cap");
	ana_cap_a: assert property (analog_rail <= 6'h22)
		else $error("ana cap");
	rail_tie_a: assert property (digital_rail == analog_rail)
		else $error("rails split");
	man_amp_a: assert property (reg_wr && reg_addr == 8'h0b && !reg_wdata[7] ##1 !reg_wr
		|=> amplifier_rail == (sup_ff ? 6'h2b : 6'h1b) + $past(reg_wdata[2:0], 2))
		else $error("amp level");
	man_ana_a: assert property (reg_wr && reg_addr == 8'h0b && !reg_wdata[7] ##1 !reg_wr
		|=> analog_rail == (sup_ff ? 6'h22 : 6'h1b + $past(reg_wdata[2:0], 2)))
		else $error("ana level");
endmodule // supply_reg_chk
bind supply_regulator_setting_control supply_reg_chk chk (.host_clock_output, .rst_b, .reg_wr, .reg_addr,
	.reg_wdata, .auto_busy, .amplifier_rail, .analog_rail, .digital_rail);

// ==== test/supply_regulator_setting_control_tb_top.sv ====
`timescale 1ns/1ps
module supply_regulator_setting_control_tb_top;
	logic host_clock_output = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, chip_activate = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [5:0] vin_level = 6'h30, amplifier_rail, analog_rail, digital_rail;
	logic regulators_on, osc_run, host_clock_output_en, auto_busy;
	int miscompares = 0, n_checks = 0;
	supply_regulator_setting_control dut (.host_clock_output, .rst_b, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .chip_activate, .vin_level, .regulators_on, .osc_run,
		.host_clock_output_en, .amplifier_rail, .analog_rail, .digital_rail, .auto_busy);
	// 40 MHz
	initial forever #12.5 host_clock_output = ~host_clock_output;
	task automatic test_done;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// called on an edge: the rails seen are the ones launched one edge earlier
	task automatic rails(input logic [5:0] a, input logic [5:0] d);
		chk({2'h0, amplifier_rail}, {2'h0, a});
		chk({2'h0, analog_rail}, {2'h0, d});
		chk({2'h0, digital_rail}, {2'h0, d});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge host_clock_output);
		reg_wr <= 1'b0;
		repeat (2) @(posedge host_clock_output);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge host_clock_output);
		reg_rd <= 1'b0;
		@(posedge host_clock_output);
		chk(reg_rdata, e);
	endtask
	// bounded wait on the routine's busy flag
	task automatic wt(input logic v);
		for (int i = 0; i < 100 && auto_busy !== v; i++) begin
			@(posedge host_clock_output);
		end
		if (auto_busy !== v) begin
			miscompares++;
			test_done;
		end
	endtask
	// main sequence
	initial begin
		repeat (8) @(posedge host_clock_output);
		rst_b <= 1'b1;
		rd(8'h00, 8'h01);
		rd(8'h0b, 8'h80);
		rails(6'h32, 6'h22);
		chip_activate <= 1'b1;
		wt(1'b1);
		wt(1'b0);
		chk({5'h0, regulators_on, osc_run, host_clock_output_en}, 8'h07);
		rails(6'h2c, 6'h22);
		wr(8'h0b, 8'h80);
		chk({7'h0, auto_busy}, 8'h00);
		for (int s = 1; s >= 0; s--) begin
			wr(8'h00, {7'h0, s[0]});
			for (int c = 0; c < 8; c++) begin
				wr(8'h0b, {5'h0, c[2:0]});
				rails(s ? 6'h2b + c[2:0] : 6'h1b + c[2:0], s ? 6'h22 : 6'h1b + c[2:0]);
			end
		end
		// supply now below 4.3 V, with the 3-V configuration kept
		vin_level <= 6'h20;
		rd(8'h00, 8'h00);
		wr(8'h0b, 8'h87);
		wt(1'b1);
		wt(1'b0);
		rd(8'h0b, 8'h87);
		rails(6'h1c, 6'h1c);
		rd(8'h05, 8'h00);
		// back to a 5-V supply high enough to hit the amplifier cap
		vin_level <= 6'h37;
		wr(8'h00, 8'h01);
		wr(8'h0b, 8'h00);
		rails(6'h2b, 6'h22);
		wr(8'h0b, 8'h80);
		wt(1'b1);
		wt(1'b0);
		rails(6'h32, 6'h22);
		test_done;
	end
endmodule // supply_regulator_setting_control_tb_top
